// file: mlog_defines.svh
/*
  constants of the maintenance log entry formatter: offsets, fields,
  entry codes, reset values and access range bounds.
  assumes it is included by bare name from the package and the module.
*/
// Contract
// - each entry opens with type byte and length byte; types 00H..03H
// - address unit select picks logical blocks (0) or physical sectors (1)
// - usage entry type 01H, length 0CH, twelve data bytes
// - usage reporting-area byte reads FFH, whole device
// - access counter counts positionings, cleared when hardware error logged
// - access count reported as four-bit decade/half-decade range code
// - six-byte blocks-read count, MSB first, bytes 4-9, units per select
// - two-byte first-retry counter, bytes 10-11
// - two-byte multiple-retry counter, once per failed-first-retry recovery
// - data error entry type 02H, length 06H
// - block address logical, or cylinder high, cylinder low, head, sector
// - error classes ORed into error code, bit 0 reserved
// - occurrence count up once per recovery uncorrectable or multi-retry
// - hardware error entry type 03H, length 08H
// - hardware error address as accessed, same layout as data error
// - internal status holds sense code, MSB set when recoverable
// - replaceable unit code byte 08 always zero
// - hardware entry byte 09 holds access range code as usage entry
// - device status code in hardware entry byte 07
`ifndef MLOG_DEFINES_SVH
`define MLOG_DEFINES_SVH

// ==========================================================
// register map (byte addresses, window selects, control bits, reset value)
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define WIN_USAGE       2'h1
`define WIN_DERR        2'h2
`define WIN_HWERR       2'h3
`define CTRL_UNIT_BIT   0
`define CTRL_CLEAR_BIT  1
`define CTRL_RESET      1'h0

// ==========================================================
// entry codes
`define TYPE_NONE       8'h00
`define TYPE_USAGE      8'h01
`define TYPE_DERR       8'h02
`define TYPE_HWERR      8'h03
`define LEN_USAGE       8'h0c
`define LEN_DERR        8'h06
`define LEN_HWERR       8'h08
`define LEN_NONE        8'h00
`define AREA_DEVICE     8'hff
`define UNIT_CODE       8'h00
`define USAGE_BYTES     14
`define DERR_BYTES      8
`define HWERR_BYTES     10

// ==========================================================
// access range upper bounds
`define RNG_2           32'd10
`define RNG_3           32'd100
`define RNG_4           32'd1000
`define RNG_5           32'd10000
`define RNG_6           32'd100000
`define RNG_7           32'd500000
`define RNG_8           32'd1000000
`define RNG_9           32'd5000000
`define RNG_A           32'd10000000
`define RNG_B           32'd50000000
`define RNG_C           32'd100000000
`define RNG_D           32'd500000000
`define RNG_E           32'd1000000000

`endif

// file: mlog_pkg.sv
/*
  types of the maintenance log entry formatter.
  assumes mlog_defines.svh sits beside it.
*/
`include "mlog_defines.svh"

package mlog_pkg;

  // ==========================================================
  // whole state of the formatter
  typedef struct packed {
    logic        unit_sel;
    logic [31:0] access_cnt;
    logic [47:0] lblk_cnt;
    logic [47:0] pblk_cnt;
    logic [15:0] first_cnt;
    logic [15:0] multi_cnt;
    logic        de_valid;
    logic [31:0] de_lba;
    logic [31:0] de_address_unit_select;
    logic [7:0]  de_code;
    logic [7:0]  de_occ;
    logic        hw_valid;
    logic [31:0] hw_lba;
    logic [31:0] hw_address_unit_select;
    logic [7:0]  hw_status;
    logic [7:0]  hw_vstat;
    logic [3:0]  hw_range;
    logic [31:0] rdata;
  } state_s;

endpackage : mlog_pkg

// file: mlog_formatter.sv
/*
  maintenance log entry formatter: usage counters, one data error record,
  one hardware error record, each readable byte by byte as log entries.
  assumes the log ram and command handling lie outside and copy entries
  out through the register port; event inputs are one-cycle pulses.
*/
`timescale 1ns/10ps
`default_nettype none

`include "mlog_defines.svh"

module mlog_formatter (
  input  wire logic        ref_clk,        // 125 MHz clock
  input  wire logic        rst_b,          // async reset, active low
  input  wire logic [7:0]  reg_addr,       // register byte address
  input  wire logic [31:0] reg_wdata,      // register write data
  input  wire logic        reg_wr,         // write strobe
  input  wire logic        reg_rd,         // read strobe
  output logic      [31:0] reg_rdata,      // read data, cycle after strobe
  output logic             address_unit_select, // 1 = physical units
  input  wire logic        seek_evt,       // one media positioning
  input  wire logic        read_evt,       // blocks were read
  input  wire logic [7:0]  read_lblocks,   // logical blocks in that read
  input  wire logic [7:0]  read_pblocks,   // physical sectors in that read
  input  wire logic        recov_evt,      // recovery action finished
  input  wire logic        recov_first_ok, // recovered on first retry
  input  wire logic        recov_multi,    // first retry failed
  input  wire logic        derr_evt,       // data error to record
  input  wire logic [31:0] derr_lba,       // logical block of error
  input  wire logic [15:0] derr_cyl,       // cylinder of error
  input  wire logic [7:0]  derr_head,      // head of error
  input  wire logic [7:0]  derr_sector,    // sector of error
  input  wire logic [7:0]  derr_class,     // error class bits 7..1
  input  wire logic        derr_count,     // uncorrectable or multi-retry
  input  wire logic        hwerr_evt,      // hardware error to record
  input  wire logic [31:0] hwerr_lba,      // logical block being accessed
  input  wire logic [15:0] hwerr_cyl,      // cylinder being accessed
  input  wire logic [7:0]  hwerr_head,     // head being accessed
  input  wire logic [7:0]  hwerr_sector,   // sector being accessed
  input  wire logic [6:0]  hwerr_asc,      // additional sense code
  input  wire logic        hwerr_recov,    // error was recoverable
  input  wire logic [7:0]  hwerr_vstat     // device-specific status
);

  // ==========================================================
  // helpers
  function automatic logic [3:0] range_code(input logic [31:0] n);
    logic [3:0] c;
    c = 4'hf;
    if (n == 32'h0000_0000)   c = 4'h0;
    else if (n == 32'h0000_0001) c = 4'h1;
    else if (n <= `RNG_2)     c = 4'h2;
    else if (n <= `RNG_3)     c = 4'h3;
    else if (n <= `RNG_4)     c = 4'h4;
    else if (n <= `RNG_5)     c = 4'h5;
    else if (n <= `RNG_6)     c = 4'h6;
    else if (n <= `RNG_7)     c = 4'h7;
    else if (n <= `RNG_8)     c = 4'h8;
    else if (n <= `RNG_9)     c = 4'h9;
    else if (n <= `RNG_A)     c = 4'ha;
    else if (n <= `RNG_B)     c = 4'hb;
    else if (n <= `RNG_C)     c = 4'hc;
    else if (n <= `RNG_D)     c = 4'hd;
    else if (n <= `RNG_E)     c = 4'he;
    return c;
  endfunction : range_code

  function automatic logic [47:0] sat_add48(input logic [47:0] a,
                                            input logic [7:0]  b);
    logic [48:0] s;
    s = {1'h0, a} + {41'h0, b};
    return s[48] ? {48{1'b1}} : s[47:0];
  endfunction : sat_add48

  function automatic logic [15:0] sat_inc16(input logic [15:0] a);
    return (a == 16'hffff) ? a : a + 16'h0001;
  endfunction : sat_inc16

  // ==========================================================
  // state
  mlog_pkg::state_s s_q;
  mlog_pkg::state_s s_d;

  logic [7:0] usage_b [`USAGE_BYTES];
  logic [7:0] derr_b  [`DERR_BYTES];
  logic [7:0] hwerr_b [`HWERR_BYTES];
  logic [3:0] acc_range;
  logic [31:0] de_addr;
  logic [31:0] hw_addr;
  logic [31:0] derr_address_unit_select;
  logic [31:0] hwerr_address_unit_select;
  logic [3:0]  idx;

  assign reg_rdata           = s_q.rdata;
  assign address_unit_select = s_q.unit_sel;

  // ==========================================================
  // entry images
  always_comb begin
    acc_range  = range_code(s_q.access_cnt);
    derr_address_unit_select  = {derr_cyl, derr_head, derr_sector};
    hwerr_address_unit_select = {hwerr_cyl, hwerr_head, hwerr_sector};
    de_addr    = s_q.unit_sel ? s_q.de_address_unit_select : s_q.de_lba;
    hw_addr    = s_q.unit_sel ? s_q.hw_address_unit_select : s_q.hw_lba;

    usage_b[0]  = `TYPE_USAGE;
    usage_b[1]  = `LEN_USAGE;
    usage_b[2]  = `AREA_DEVICE;
    usage_b[3]  = {4'h0, acc_range};
    for (int i = 0; i < 6; i++) begin
      usage_b[4 + i] = s_q.unit_sel ? s_q.pblk_cnt[47 - 8 * i -: 8]
                                    : s_q.lblk_cnt[47 - 8 * i -: 8];
    end
    usage_b[10] = s_q.first_cnt[15:8];
    usage_b[11] = s_q.first_cnt[7:0];
    usage_b[12] = s_q.multi_cnt[15:8];
    usage_b[13] = s_q.multi_cnt[7:0];

    // an empty slot reads as a no-information entry
    derr_b[0] = s_q.de_valid ? `TYPE_DERR : `TYPE_NONE;
    derr_b[1] = s_q.de_valid ? `LEN_DERR : `LEN_NONE;
    for (int i = 0; i < 4; i++) begin
      derr_b[2 + i]  = de_addr[31 - 8 * i -: 8];
      hwerr_b[2 + i] = hw_addr[31 - 8 * i -: 8];
    end
    derr_b[6] = s_q.de_code;
    derr_b[7] = s_q.de_occ;

    hwerr_b[0] = s_q.hw_valid ? `TYPE_HWERR : `TYPE_NONE;
    hwerr_b[1] = s_q.hw_valid ? `LEN_HWERR : `LEN_NONE;
    hwerr_b[6] = s_q.hw_status;
    hwerr_b[7] = s_q.hw_vstat;
    hwerr_b[8] = `UNIT_CODE;
    hwerr_b[9] = {4'h0, s_q.hw_range};
  end

  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;
    idx = reg_addr[5:2];

    // access counter; a logged hardware error restarts it, and a
    // positioning in the same cycle is counted into the new span
    if (hwerr_evt) begin
      s_d.access_cnt = {31'h0, seek_evt};
    end else if (seek_evt && s_q.access_cnt != 32'hffff_ffff) begin
      s_d.access_cnt = s_q.access_cnt + 32'h0000_0001;
    end

    // both unit counts kept so the select can change at any time
    if (read_evt) begin
      s_d.lblk_cnt = sat_add48(s_q.lblk_cnt, read_lblocks);
      s_d.pblk_cnt = sat_add48(s_q.pblk_cnt, read_pblocks);
    end
    if (recov_evt && recov_first_ok) begin
      s_d.first_cnt = sat_inc16(s_q.first_cnt);
    end
    if (recov_evt && recov_multi) begin
      s_d.multi_cnt = sat_inc16(s_q.multi_cnt);
    end

    // software side: control write and clear of the error records
    if (reg_wr && reg_addr == `REG_CTRL) begin
      s_d.unit_sel = reg_wdata[`CTRL_UNIT_BIT];
      if (reg_wdata[`CTRL_CLEAR_BIT]) begin
        s_d.de_valid = 1'h0;
        s_d.hw_valid = 1'h0;
      end
    end

    // data error record; events below override a same-cycle clear
    if (derr_evt) begin
      if (s_d.de_valid && s_q.de_lba == derr_lba) begin
        s_d.de_code = s_q.de_code | {derr_class[7:1], 1'h0};
        if (derr_count && s_q.de_occ != 8'hff) begin
          s_d.de_occ = s_q.de_occ + 8'h01;
        end
      end else begin
        s_d.de_lba  = derr_lba;
        s_d.de_address_unit_select = derr_address_unit_select;
        s_d.de_code = {derr_class[7:1], 1'h0};
        s_d.de_occ  = {7'h0, derr_count};
      end
      s_d.de_valid = 1'h1;
    end

    if (hwerr_evt) begin
      s_d.hw_valid  = 1'h1;
      s_d.hw_lba    = hwerr_lba;
      s_d.hw_address_unit_select   = hwerr_address_unit_select;
      s_d.hw_status = {hwerr_recov, hwerr_asc};
      s_d.hw_vstat  = hwerr_vstat;
      s_d.hw_range  = acc_range;
    end

    // read data: valid only in the cycle after the strobe
    s_d.rdata = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr[7:6])
        2'h0: begin
          if (reg_addr == `REG_CTRL) begin
            s_d.rdata = {31'h0, s_q.unit_sel};
          end else if (reg_addr == `REG_STATUS) begin
            s_d.rdata = {24'h0, acc_range, 2'h0, s_q.hw_valid, s_q.de_valid};
          end
        end
        `WIN_USAGE: begin
          if (idx < 4'(`USAGE_BYTES)) s_d.rdata = {24'h0, usage_b[idx]};
        end
        `WIN_DERR: begin
          if (idx < 4'(`DERR_BYTES)) s_d.rdata = {24'h0, derr_b[idx[2:0]]};
        end
        `WIN_HWERR: begin
          if (idx < 4'(`HWERR_BYTES)) s_d.rdata = {24'h0, hwerr_b[idx]};
        end
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q          <= '0;
      s_q.unit_sel <= `CTRL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : mlog_formatter

`default_nettype wire

// file: mlog_formatter_sva.sv
/* port checker of the maintenance log formatter.
   assumes it is bound to mlog_formatter from the bench top file. */
`timescale 1ns/10ps
`default_nettype none
module mlog_formatter_sva (
  input wire logic        ref_clk,            // clock
  input wire logic        rst_b,              // reset, active low
  input wire logic [7:0]  reg_addr,           // byte address
  input wire logic [31:0] reg_wdata,          // write data
  input wire logic        reg_wr,             // write strobe
  input wire logic        reg_rd,             // read strobe
  input wire logic [31:0] reg_rdata,          // read data
  input wire logic        address_unit_select // unit select
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic       rd_q;
  logic [7:0] a_q;
  // ==========================================================
  // read taken last cycle, answer due now
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_q <= 1'b0;
      a_q  <= 8'h00;
    end else begin
      rd_q <= reg_rd;
      a_q  <= reg_addr;
    end
  end
  a_idle_zero: assert property (!rd_q |-> reg_rdata == 32'h0)
    else $error("read data not zero outside an answer");
  a_usage_type: assert property (rd_q && a_q == 8'h40 |-> reg_rdata == 32'h01)
    else $error("usage type byte wrong");
  a_usage_len: assert property (rd_q && a_q == 8'h44 |-> reg_rdata == 32'h0c)
    else $error("usage length byte wrong");
  a_area_all: assert property (rd_q && a_q == 8'h48 |-> reg_rdata == 32'hff)
    else $error("reporting area byte wrong");
  a_derr_len: assert property (rd_q && a_q == 8'h84 |-> reg_rdata inside {32'h0, 32'h06})
    else $error("data error length byte wrong");
  a_hw_len: assert property (rd_q && a_q == 8'hc4 |-> reg_rdata inside {32'h0, 32'h08})
    else $error("hardware error length byte wrong");
  a_unit_zero: assert property (rd_q && a_q == 8'he0 |-> reg_rdata == 32'h0)
    else $error("replaceable unit byte not zero");
  a_byte_wide: assert property (rd_q && a_q >= 8'h40 |-> reg_rdata[31:8] == 24'h0)
    else $error("entry byte wider than eight bits");
  a_unit_follow: assert property (reg_wr && reg_addr == 8'h00 |=>
    address_unit_select == $past(reg_wdata[0]))
    else $error("unit select did not follow write");
  a_unit_hold: assert property (!reg_wr |=> $stable(address_unit_select))
    else $error("unit select moved without write");
endmodule : mlog_formatter_sva
`default_nettype wire

// file: log_initiator.sv
/* initiator model: reads log bytes and sets request bits over the port.
   assumes the bench calls its tasks hierarchically, one at a time. */
`timescale 1ns/10ps
`default_nettype none
module log_initiator (
  input  wire logic        ref_clk,   // clock
  output var  logic [7:0]  reg_addr,  // byte address
  output var  logic [31:0] reg_wdata, // write data
  output var  logic        reg_wr,    // write strobe
  output var  logic        reg_rd     // read strobe
);
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
  end
  // idle address is inverted after each access, and data after a write, so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge ref_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge ref_clk);
    {reg_rd, reg_addr} <= {1'b0, ~a};
  endtask : rd
endmodule : log_initiator
`default_nettype wire

// file: mlog_formatter_tb.sv
/* self-checking bench of the maintenance log formatter.
   assumes log_initiator and the checker are compiled beside it. */
`timescale 1ns/10ps
`default_nettype none
module mlog_formatter_tb;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  reg_addr, read_lblocks, read_pblocks, derr_head, derr_sector, derr_class;
  logic [7:0]  hwerr_head, hwerr_sector, hwerr_vstat;
  logic [31:0] reg_wdata, reg_rdata, derr_lba, hwerr_lba;
  logic [15:0] derr_cyl, hwerr_cyl, s;
  logic [6:0]  hwerr_asc;
  logic        reg_wr, reg_rd, address_unit_select, seek_evt, read_evt, recov_evt;
  logic        recov_first_ok, recov_multi, derr_evt, derr_count, hwerr_evt, hwerr_recov;
  logic [159:0] rnd;
  logic [31:0] exp_q[$];
  logic [7:0]  adr_q[$];
  logic        rd_seen = 1'b0;
  int          miscompares = 0;
  int          total_checks = 0;
  always #4 ref_clk = ~ref_clk;
  log_initiator host (.ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
  mlog_formatter dut (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .address_unit_select, .seek_evt, .read_evt, .read_lblocks, .read_pblocks, .recov_evt,
    .recov_first_ok, .recov_multi, .derr_evt, .derr_lba, .derr_cyl, .derr_head,
    .derr_sector, .derr_class, .derr_count, .hwerr_evt, .hwerr_lba, .hwerr_cyl,
    .hwerr_head, .hwerr_sector, .hwerr_asc, .hwerr_recov, .hwerr_vstat);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    adr_q.push_back(a);
    host.rd(a);
  endtask : rd_chk
  task automatic addr_chk(input logic [7:0] base, input logic [31:0] v);
    for (int i = 0; i < 4; i++) rd_chk(base + 8'(4 * i), {24'h0, v[31 - 8 * i -: 8]});
  endtask : addr_chk
  task automatic seeks(input int n);
    @(posedge ref_clk) seek_evt <= 1'b1;
    repeat (n) @(posedge ref_clk);
    seek_evt <= 1'b0;
  endtask : seeks
  // ==========================================================
  // answer monitor: read data stand in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rd_seen) check($sformatf("byte %h", adr_q.pop_front()), reg_rdata, exp_q.pop_front());
    rd_seen = reg_rd;
  end
  initial begin
    #200000;
    miscompares++;
    conclude();
  end
  // ==========================================================
  // main sequence
  initial begin
    {seek_evt, read_evt, recov_evt, recov_first_ok, recov_multi} = '0;
    {derr_evt, derr_count, hwerr_evt, hwerr_recov, derr_class} = '0;
    void'($urandom(59680));
    rnd = {$urandom, $urandom, $urandom, $urandom, $urandom};
    {derr_lba, derr_cyl, derr_head, derr_sector, hwerr_lba, hwerr_cyl, hwerr_head,
      hwerr_sector, hwerr_asc, hwerr_vstat, read_lblocks, read_pblocks} = rnd[158:0];
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd_chk(8'h40, 32'h01);
    rd_chk(8'h4c, 32'h00);
    rd_chk(8'hc0, 32'h00);
    rd_chk(8'hfc, 32'h00);
    seeks(1);
    rd_chk(8'h4c, 32'h01);
    seeks(9);
    rd_chk(8'h4c, 32'h02);
    seeks(1);
    rd_chk(8'h4c, 32'h03);
    $display("test access range done");
    @(posedge ref_clk) read_evt <= 1'b1;
    repeat (2) @(posedge ref_clk);
    read_evt <= 1'b0;
    s = {7'h0, read_lblocks, 1'b0};
    rd_chk(8'h50, 32'h00);
    rd_chk(8'h60, {24'h0, s[15:8]});
    rd_chk(8'h64, {24'h0, s[7:0]});
    host.wr(8'h00, 32'h1);
    s = {7'h0, read_pblocks, 1'b0};
    rd_chk(8'h60, {24'h0, s[15:8]});
    rd_chk(8'h64, {24'h0, s[7:0]});
    @(posedge ref_clk) {recov_evt, recov_first_ok} <= 2'b11;
    @(posedge ref_clk) {recov_first_ok, recov_multi} <= 2'b01;
    @(posedge ref_clk) {recov_first_ok, recov_multi} <= 2'b10;
    @(posedge ref_clk) {recov_evt, recov_first_ok} <= 2'b00;
    rd_chk(8'h6c, 32'h02);
    rd_chk(8'h74, 32'h01);
    $display("test usage counters done");
    @(posedge ref_clk) {derr_evt, derr_count, derr_class} <= {2'b11, 8'h24};
    @(posedge ref_clk) derr_class <= 8'h09;
    @(posedge ref_clk) derr_evt <= 1'b0;
    addr_chk(8'h88, {derr_cyl, derr_head, derr_sector});
    host.wr(8'h00, 32'h0);
    rd_chk(8'h80, 32'h02);
    rd_chk(8'h84, 32'h06);
    addr_chk(8'h88, derr_lba);
    rd_chk(8'h98, 32'h2c);
    rd_chk(8'h9c, 32'h02);
    $display("test data error done");
    @(posedge ref_clk) {hwerr_evt, hwerr_recov} <= 2'b11;
    @(posedge ref_clk) hwerr_evt <= 1'b0;
    rd_chk(8'hc0, 32'h03);
    addr_chk(8'hc8, hwerr_lba);
    rd_chk(8'hd8, {24'h0, 1'b1, hwerr_asc});
    rd_chk(8'hdc, {24'h0, hwerr_vstat});
    rd_chk(8'he0, 32'h00);
    rd_chk(8'he4, 32'h03);
    rd_chk(8'h4c, 32'h00);
    @(posedge ref_clk) {hwerr_evt, hwerr_recov, seek_evt} <= 3'b101;
    @(posedge ref_clk) {hwerr_evt, seek_evt} <= 2'b00;
    host.wr(8'h00, 32'h1);
    // the select flop loads at the edge the task returns on; look mid-cycle
    @(negedge ref_clk);
    check("unit select", {31'h0, address_unit_select}, 32'h1);
    rd_chk(8'h00, 32'h01);
    addr_chk(8'hc8, {hwerr_cyl, hwerr_head, hwerr_sector});
    rd_chk(8'hd8, {24'h0, 1'b0, hwerr_asc});
    rd_chk(8'he4, 32'h00);
    rd_chk(8'h4c, 32'h01);
    rd_chk(8'h04, 32'h13);
    host.wr(8'h00, 32'h2);
    rd_chk(8'hc0, 32'h00);
    rd_chk(8'h80, 32'h00);
    rd_chk(8'h04, 32'h10);
    rd_chk(8'h00, 32'h00);
    // second reset in mid-run: counters and records start over
    @(posedge ref_clk) rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd_chk(8'h4c, 32'h00);
    rd_chk(8'h6c, 32'h00);
    rd_chk(8'h04, 32'h00);
    repeat (3) @(posedge ref_clk);
    $display("test hardware error done");
    conclude();
  end
endmodule : mlog_formatter_tb
bind mlog_formatter mlog_formatter_sva chk (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .address_unit_select);
`default_nettype wire
